//--- src/qdac_pkg.sv
// package: constants, commands and channel codes for the quad dac command logic
`default_nettype none
package qdac_pkg;
   localparam int CHANNELS = 4;
   localparam int DATA_W = 16;
   localparam int WORD_W = 32;
   // -----------------------------------------------
   // input word layout
   // -----------------------------------------------
   localparam int CMD_HI = 23;
   localparam int CMD_LO = 20;
   localparam int CHAN_HI = 19;
   localparam int CHAN_LO = 16;
   localparam int DATA_HI = 15;
   localparam int DATA_LO = 0;
   localparam logic [3:0] CMD_WRITE = 4'h0;
   localparam logic [3:0] CMD_UPDATE = 4'h1;
   localparam logic [3:0] CMD_WRITE_UPD_ALL = 4'h2;
   localparam logic [3:0] CMD_WRITE_UPD = 4'h3;
   localparam logic [3:0] CMD_POWER_DOWN = 4'h4;
   localparam logic [3:0] CMD_NOP = 4'hF;
   localparam logic [3:0] CHAN_A = 4'h0;
   localparam logic [3:0] CHAN_B = 4'h1;
   localparam logic [3:0] CHAN_C = 4'h2;
   localparam logic [3:0] CHAN_D = 4'h3;
   localparam logic [3:0] CHAN_ALL = 4'hF;
   // -----------------------------------------------
   // timing
   // -----------------------------------------------
   localparam int CLOCK_HZ = 25_000_000;
   localparam int WAKE_SHORT_NS = 5_000;
   localparam int WAKE_LONG5V_NS = 12_000;
   localparam int WAKE_LONG3V_NS = 30_000;
   localparam int WAKE_SHORT_CYC = (WAKE_SHORT_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
   localparam int WAKE_LONG5V_CYC = (WAKE_LONG5V_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
   localparam int WAKE_LONG3V_CYC = (WAKE_LONG3V_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
   localparam int TIMER_W = 10;
   localparam logic [DATA_W-1:0] CODE_RESET = 16'h0000;
   localparam int FIFO_DEPTH = 8;
endpackage : qdac_pkg
`default_nettype wire

//--- src/qdac_command_update.sv
// design: command fifo and command execution logic for the quad dac
`default_nettype none
// -----------------------------------------------
// word fifo
// -----------------------------------------------
module qdac_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_reg;
   logic [AW-1:0] rdPtr_reg;
   logic [AW:0] count_reg;
   logic doWrite;
   logic doRead;
   assign doWrite = inValid && inReady;
   assign doRead = outValid && outReady;
   assign inReady = (count_reg != (AW+1)'(DEPTH));
   assign outValid = (count_reg != '0);
   assign outData = mem[rdPtr_reg];
   always_ff @(posedge clock)
   begin
      if (doWrite)
      begin
         mem[wrPtr_reg] <= inData;
      end
   end
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         if (doWrite)
         begin
            wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + AW'(1);
         end
         if (doRead)
         begin
            rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + AW'(1);
         end
         if (doWrite && !doRead)
         begin
            count_reg <= count_reg + (AW+1)'(1);
         end
         else if (doRead && !doWrite)
         begin
            count_reg <= count_reg - (AW+1)'(1);
         end
      end
   end
endmodule : qdac_fifo

// -----------------------------------------------
// command execution top
// -----------------------------------------------
module qdac_command_update
   import qdac_pkg::*;
#(
   parameter int RESOLUTION = 16,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic wordValid,
   output logic wordReady,
   input wire logic [WORD_W-1:0] wordData,
   input wire logic supplyLow,
   output logic [4*DATA_W-1:0] outputCode,
   output logic [CHANNELS-1:0] channelAsleep,
   output logic [CHANNELS-1:0] outputHighZ_n,
   output logic [CHANNELS-1:0] settling,
   output logic biasOff,
   output logic badCommand
);
   typedef enum logic [1:0] {
      QDAC_IDLE = 2'b01,
      QDAC_WAKE = 2'b10
   } qdac_state_t;

   localparam logic [DATA_W-1:0] KEEP_MASK = ~((16'h0001 << (DATA_W - RESOLUTION)) - 16'h0001);

   logic fifoReady;
   logic cmdValid;
   logic [WORD_W-1:0] cmdWord;
   logic cmdTake;
   logic [3:0] cmdCode;
   logic [3:0] chanCode;
   logic [DATA_W-1:0] dataWord;
   logic [CHANNELS-1:0] selMask;
   logic selValid;
   logic doWrite;
   logic doUpdate;
   logic updAll;
   logic doSleep;
   logic [CHANNELS-1:0] updMask;
   logic [CHANNELS-1:0] wakeMask;
   logic [DATA_W-1:0] inputReg_reg [CHANNELS];
   logic [DATA_W-1:0] dacReg_reg [CHANNELS];
   logic [CHANNELS-1:0] asleep_reg;
   logic [CHANNELS-1:0] settling_reg;
   logic [TIMER_W-1:0] timer_reg;
   logic bad_reg;
   logic supplyLowMeta_reg;
   logic supplyLowSync_reg;
   qdac_state_t state_reg;

   qdac_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) cmdFifo (
      .clock(clock),
      .rst(rst),
      .inValid(wordValid),
      .inReady(fifoReady),
      .inData(wordData),
      .outValid(cmdValid),
      .outReady(cmdTake),
      .outData(cmdWord)
   );

   // commands wait while a wake delay runs, so settling is never cut short
   assign cmdTake = cmdValid && (state_reg == QDAC_IDLE);
   assign cmdCode = cmdWord[CMD_HI:CMD_LO];
   assign chanCode = cmdWord[CHAN_HI:CHAN_LO];
   assign dataWord = cmdWord[DATA_HI:DATA_LO] & KEEP_MASK;

   always_comb
   begin
      selValid = 1'b1;
      case (chanCode)
         CHAN_A: selMask = 4'h1;
         CHAN_B: selMask = 4'h2;
         CHAN_C: selMask = 4'h4;
         CHAN_D: selMask = 4'h8;
         CHAN_ALL: selMask = 4'hF;
         default:
         begin
            selMask = 4'h0;
            selValid = 1'b0;
         end
      endcase
      doWrite = 1'b0;
      doUpdate = 1'b0;
      updAll = 1'b0;
      doSleep = 1'b0;
      case (cmdCode)
         CMD_WRITE: doWrite = 1'b1;
         CMD_UPDATE: doUpdate = 1'b1;
         CMD_WRITE_UPD_ALL:
         begin
            doWrite = 1'b1;
            updAll = 1'b1;
         end
         CMD_WRITE_UPD:
         begin
            doWrite = 1'b1;
            doUpdate = 1'b1;
         end
         CMD_POWER_DOWN: doSleep = 1'b1;
         CMD_NOP: ;
         default: selValid = 1'b0;
      endcase
      updMask = updAll ? 4'hF : (doUpdate ? selMask : 4'h0);
      wakeMask = updMask & asleep_reg;
   end

   // reserved codes are dropped whole; a flag tells the system it happened
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < CHANNELS; i++)
         begin
            inputReg_reg[i] <= CODE_RESET;
            dacReg_reg[i] <= CODE_RESET;
         end
      end
      else if (cmdTake && selValid)
      begin
         for (int i = 0; i < CHANNELS; i++)
         begin
            if (doWrite && selMask[i])
            begin
               inputReg_reg[i] <= dataWord;
            end
            if (updMask[i])
            begin
               // write then update of the same word lands the new data
               dacReg_reg[i] <= (doWrite && selMask[i]) ? dataWord : inputReg_reg[i];
            end
         end
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         asleep_reg <= '0;
      end
      else if (cmdTake && selValid)
      begin
         // power-down touches only the sleep bits
         asleep_reg <= (asleep_reg | (doSleep ? selMask : 4'h0)) & ~updMask;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         bad_reg <= 1'b0;
      end
      else if (cmdTake)
      begin
         bad_reg <= !selValid;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         supplyLowMeta_reg <= 1'b0;
         supplyLowSync_reg <= 1'b0;
      end
      else
      begin
         supplyLowMeta_reg <= supplyLow;
         supplyLowSync_reg <= supplyLowMeta_reg;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= QDAC_IDLE;
         timer_reg <= '0;
         settling_reg <= '0;
      end
      else
      begin
         case (state_reg)
            QDAC_IDLE:
            begin
               if (cmdTake && selValid && (wakeMask != 4'h0))
               begin
                  state_reg <= QDAC_WAKE;
                  settling_reg <= wakeMask;
                  if (asleep_reg == 4'hF)
                  begin
                     timer_reg <= supplyLowSync_reg ? TIMER_W'(WAKE_LONG3V_CYC - 1) : TIMER_W'(WAKE_LONG5V_CYC - 1);
                  end
                  else
                  begin
                     timer_reg <= TIMER_W'(WAKE_SHORT_CYC - 1);
                  end
               end
            end
            QDAC_WAKE:
            begin
               if (timer_reg == '0)
               begin
                  state_reg <= QDAC_IDLE;
                  settling_reg <= '0;
               end
               else
               begin
                  timer_reg <= timer_reg - TIMER_W'(1);
               end
            end
            default: state_reg <= QDAC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         outputCode <= '0;
         channelAsleep <= '0;
         outputHighZ_n <= '1;
         settling <= '0;
         biasOff <= 1'b0;
         badCommand <= 1'b0;
         wordReady <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < CHANNELS; i++)
         begin
            outputCode[i*DATA_W +: DATA_W] <= dacReg_reg[i];
         end
         channelAsleep <= asleep_reg;
         outputHighZ_n <= ~asleep_reg;
         settling <= settling_reg;
         biasOff <= (asleep_reg == 4'hF);
         badCommand <= bad_reg;
         wordReady <= fifoReady;
      end
   end

   // -----------------------------------------------
   // checks
   // -----------------------------------------------
   sleep_keeps_code_a: assert property (@(posedge clock) disable iff (rst)
      (cmdTake && doSleep) |=> $stable(dacReg_reg[0]) && $stable(inputReg_reg[0]))
      else $error("power-down changed channel registers");
   update_wakes_a: assert property (@(posedge clock) disable iff (rst)
      (cmdTake && selValid && updMask[0]) |=> !asleep_reg[0])
      else $error("update left channel asleep");
   sleep_sets_a: assert property (@(posedge clock) disable iff (rst)
      (cmdTake && selValid && doSleep && selMask[1]) |=> asleep_reg[1])
      else $error("power-down missed channel");
   only_update_wakes_a: assert property (@(posedge clock) disable iff (rst)
      $fell(asleep_reg[2]) |-> $past(cmdTake && updMask[2]))
      else $error("channel woke without update");
   write_loads_a: assert property (@(posedge clock) disable iff (rst)
      (cmdTake && cmdCode == CMD_WRITE && chanCode == CHAN_B) |=> inputReg_reg[1] == $past(dataWord))
      else $error("write did not load input register");
   update_copies_a: assert property (@(posedge clock) disable iff (rst)
      (cmdTake && cmdCode == CMD_UPDATE && chanCode == CHAN_C) |=> dacReg_reg[2] == $past(inputReg_reg[2]))
      else $error("update did not copy input register");
   short_wake_a: assert property (@(posedge clock) disable iff (rst)
      (cmdTake && selValid && wakeMask != 4'h0 && asleep_reg != 4'hF) |=>
      (state_reg == QDAC_WAKE && timer_reg == TIMER_W'(WAKE_SHORT_CYC - 1)) ##124
      (state_reg == QDAC_WAKE && timer_reg == '0) ##1 state_reg == QDAC_IDLE)
      else $error("short wake delay wrong");
   highz_follows_a: assert property (@(posedge clock) disable iff (rst)
      asleep_reg[3] |=> !outputHighZ_n[3])
      else $error("sleeping output not high impedance");
   bias_off_a: assert property (@(posedge clock) disable iff (rst)
      (asleep_reg == 4'hF) |=> biasOff)
      else $error("bias not off with all asleep");
endmodule : qdac_command_update
`default_nettype wire

//--- tb/qdac_word_source.sv
// bench partner: host side that offers 32-bit command words on valid/ready
`default_nettype none
module qdac_word_source
   import qdac_pkg::*;
(
   input wire logic clock,
   input wire logic wordReady,
   output var logic wordValid,
   output var logic [WORD_W-1:0] wordData
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      wordValid = 1'b0;
      wordData = 32'h0000_0000;
   end
   // -----------------------------------------------
   // one word per command, held until taken
   // -----------------------------------------------
   // ready is registered, so its value at the falling edge holds through the next rising edge
   task send(input logic [WORD_W-1:0] w, output bit ok);
      ok = 1'b0;
      @(posedge clock);
      wordValid <= 1'b1;
      wordData <= w;
      for (int i = 0; i < 200 && !ok; i++)
      begin
         @(negedge clock);
         ok = (wordReady === 1'b1);
      end
      @(posedge clock);
      wordValid <= 1'b0;
      // released data does not keep showing the last word
      wordData <= ~w;
   endtask : send
endmodule : qdac_word_source
`default_nettype wire

//--- tb/quad_dac_command_update_logic_tb_top.sv
// bench top: scenario tasks for the quad dac command execution logic
`default_nettype none
module quad_dac_command_update_logic_tb_top
   import qdac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic supplyLow = 1'b0;
   logic wordValid, wordReady, biasOff, badCommand;
   logic [WORD_W-1:0] wordData;
   logic [4*DATA_W-1:0] outputCode, exp;
   logic [CHANNELS-1:0] channelAsleep, outputHighZ_n, settling;
   int fails = 0;
   int n_compared = 0;
   always #20 clock = ~clock;
   qdac_command_update #(.RESOLUTION(16), .DEPTH(FIFO_DEPTH)) uut (.clock(clock), .rst(rst),
      .wordValid(wordValid), .wordReady(wordReady), .wordData(wordData), .supplyLow(supplyLow),
      .outputCode(outputCode), .channelAsleep(channelAsleep), .outputHighZ_n(outputHighZ_n),
      .settling(settling), .biasOff(biasOff), .badCommand(badCommand));
   qdac_word_source src (.clock(clock), .wordReady(wordReady), .wordValid(wordValid), .wordData(wordData));
   // -----------------------------------------------
   // shared tasks
   // -----------------------------------------------
   task chk(input logic [63:0] got, input logic [63:0] want);
      n_compared++;
      if (got !== want)
      begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask : chk
   task conclude;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : conclude
   task put(input logic [3:0] c, input logic [3:0] h, input logic [15:0] d);
      bit ok;
      src.send({8'h00, c, h, d}, ok);
      if (!ok)
      begin
         fails++;
         conclude();
      end
   endtask : put
   // waits out execution and any wake delay
   task tx(input logic [3:0] c, input logic [3:0] h, input logic [15:0] d);
      put(c, h, d);
      repeat (4) @(posedge clock);
      for (int i = 0; i < 2000 && settling !== 4'h0; i++)
         @(posedge clock);
      #1;
      chk(settling, 4'h0);
   endtask : tx
   task wake(input logic [3:0] h, input int idx, input int want);
      int n;
      n = 0;
      put(CMD_UPDATE, h, 16'h0000);
      for (int i = 0; i < 1000; i++)
      begin
         @(posedge clock);
         #1;
         if (settling[idx] === 1'b1)
            n++;
         else if (n > 0)
            break;
      end
      chk(n, want);
      chk(channelAsleep[idx], 1'b0);
      chk(outputHighZ_n[idx], 1'b1);
   endtask : wake
   // -----------------------------------------------
   // scenarios
   // -----------------------------------------------
   task t_reset;
      chk(outputCode, 64'h0000_0000_0000_0000);
      chk({channelAsleep, outputHighZ_n, biasOff, badCommand}, 10'h03C);
      $display("test reset done");
   endtask : t_reset
   task t_write_then_update;
      tx(CMD_WRITE, CHAN_A, 16'h1234);
      chk(outputCode, 64'h0000_0000_0000_0000);
      tx(CMD_UPDATE, CHAN_A, 16'hFFFF);
      chk(outputCode, 64'h0000_0000_0000_1234);
      $display("test write then update done");
   endtask : t_write_then_update
   task t_channels;
      for (int i = 0; i < 4; i++)
      begin
         tx(CMD_WRITE_UPD, 4'(i), 16'hA000 + 16'(i));
         chk(outputCode[16*i +: 16], 16'hA000 + 16'(i));
      end
      tx(CMD_WRITE_UPD, CHAN_ALL, 16'h5555);
      chk(outputCode, 64'h5555_5555_5555_5555);
      tx(CMD_WRITE, CHAN_B, 16'h0BBB);
      tx(CMD_WRITE_UPD_ALL, CHAN_A, 16'h0AAA);
      exp = 64'h5555_5555_0BBB_0AAA;
      chk(outputCode, exp);
      $display("test channel codes done");
   endtask : t_channels
   task t_power_down;
      tx(CMD_POWER_DOWN, CHAN_C, 16'hFFFF);
      chk({channelAsleep, outputHighZ_n, biasOff}, 9'h096);
      chk(outputCode, exp);
      tx(CMD_WRITE, CHAN_D, 16'h0DDD);
      chk(channelAsleep, 4'h4);
      wake(CHAN_C, 2, WAKE_SHORT_CYC);
      chk(outputCode, exp);
      $display("test power down done");
   endtask : t_power_down
   task t_bias;
      for (int s = 0; s < 2; s++)
      begin
         supplyLow <= s[0];
         tx(CMD_POWER_DOWN, CHAN_ALL, 16'h0000);
         chk({channelAsleep, outputHighZ_n, biasOff}, 9'h1E1);
         wake(CHAN_ALL, 3, s ? WAKE_LONG3V_CYC : WAKE_LONG5V_CYC);
         chk(biasOff, 1'b0);
      end
      exp[63:48] = 16'h0DDD;
      chk(outputCode, exp);
      $display("test bias wake done");
   endtask : t_bias
   task t_reserved;
      tx(4'h7, CHAN_A, 16'h1111);
      chk(badCommand, 1'b1);
      tx(CMD_NOP, CHAN_A, 16'h2222);
      chk(badCommand, 1'b0);
      tx(CMD_WRITE_UPD, 4'h6, 16'h3333);
      chk(badCommand, 1'b1);
      chk(outputCode, exp);
      $display("test reserved codes done");
   endtask : t_reserved
   initial
   begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      #1;
      t_reset();
      repeat (2) @(posedge clock);
      t_write_then_update();
      t_channels();
      t_power_down();
      t_bias();
      t_reserved();
      conclude();
   end
endmodule : quad_dac_command_update_logic_tb_top
`default_nettype wire
